/* File: inc/occ_map.svh */
// register offsets, field positions, reset values for the output compare channel
`ifndef OCC_MAP_SVH
`define OCC_MAP_SVH
// ----------------------------------------
// byte offsets
// ----------------------------------------
`define OCC_CTRL_OFS 12'h000
`define OCC_PRI_OFS 12'h004
`define OCC_SEC_OFS 12'h008
`define OCC_CFG_OFS 12'h00c
`define OCC_STS_OFS 12'h010
`define OCC_CLR_OFS 12'h014
`define OCC_IEN_OFS 12'h018
// ----------------------------------------
// decoded register index
// ----------------------------------------
`define OCC_IDX_CTRL 3'd0
`define OCC_IDX_PRI 3'd1
`define OCC_IDX_SEC 3'd2
`define OCC_IDX_CFG 3'd3
`define OCC_IDX_STS 3'd4
`define OCC_IDX_CLR 3'd5
`define OCC_IDX_IEN 3'd6
`define OCC_IDX_NONE 3'd7
// ----------------------------------------
// control fields
// ----------------------------------------
`define OCC_IDLE_BIT 13
`define OCC_FLT_BIT 4
`define OCC_MODE_MSB 2
`define OCC_MODE_LSB 0
`define OCC_TSEL_BIT 0
`define OCC_EVT_BIT 0
// ----------------------------------------
// reset values
// ----------------------------------------
`define OCC_CMP_RST 16'h0000
`define OCC_RDATA_RST 32'h0000_0000
`endif

/* File: inc/occ_pkg.sv */
// types shared by the output compare channel
package occ_pkg;
  // codes follow declaration order: 000 .. 111
  typedef enum logic [2:0] {
    mode_off,
    mode_rise,
    mode_fall,
    mode_toggle,
    mode_one_pulse,
    mode_pulse_train,
    mode_pwm,
    mode_pwm_fault
  } mode_t;

  typedef struct packed {
    logic idle_stop;
    mode_t mode;
    logic flt;
    logic tsel;
    logic [15:0] pri;
    logic [15:0] sec;
    logic [15:0] duty;
    logic out;
    mode_t last_mode;
    logic done;
    logic flt_n_prev;
    logic sts;
    logic ien;
    logic [31:0] rdata;
  } state_t;
endpackage : occ_pkg

/* File: src/compare_match_unit.sv */
// one-cycle match pulse when a timer steps onto a compare value
`timescale 1ns/1ps
module compare_match_unit #(
  parameter int W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] count,
  input wire logic [W-1:0] cmp,
  output logic hit
);
  import occ_pkg::*;

  typedef struct packed {
    logic [W-1:0] prev;
    logic hit;
  } match_state_t;

  match_state_t m_ff;
  match_state_t nxt_m;

  if (W < 2 || W > 16) begin : g_chk
    $error("compare_match_unit: W must lie in 2..16");
  end

  // ----------------------------------------
  // match detect
  // ----------------------------------------
  // a timer held on one value for many clocks gives only one match
  always_comb begin
    nxt_m = m_ff;
    nxt_m.prev = count;
    nxt_m.hit = (count == cmp) && (count != m_ff.prev);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_ff <= '0;
    end else begin
      m_ff <= nxt_m;
    end
  end

  assign hit = m_ff.hit;
endmodule : compare_match_unit

/* File: src/output_compare_channel.sv */
// output compare channel with apb registers and interrupt
//
// Overview of operation
// - idle-stop bit set: channel halts while cpu is idle
// - fault flag set by hardware on fault, cleared only by hardware
// - fault flag updated only in mode 111, otherwise held clear
// - mode 111: pwm on output pin with fault input watched
// - mode 110: pwm on output pin, fault input ignored
// - mode 101: start low, then continuous pulses from compare matches
// - mode 100: start low, then exactly one pulse from compare matches
// - mode 011: each match inverts the pin, starting level kept
// - mode 010: start high, match drives pin low
// - mode 001: start low, match drives pin high
// - mode 000: disabled, no compares, pin back to general purpose
// - control bits 15-14, 12-5 and 3 read as zero
// - time base is one of two timers, chosen by configuration
// - fault in mode 111 puts output pin in high impedance
// - interrupt on mode-specific output edge in modes 001-101, fault onset in 111, none in 110
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "occ_map.svh"
module output_compare_channel #(
  parameter int AW = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] tmr_a_count,
  input wire logic tmr_a_rollover,
  input wire logic [15:0] tmr_b_count,
  input wire logic tmr_b_rollover,
  input wire logic cpu_idle,
  input wire logic compare_fault_input_n,
  output logic compare_output_pin_o,
  output logic compare_output_pin_oe_n,
  output logic gpio_owned,
  output logic irq
);
  import occ_pkg::*;

  state_t s_ff;
  state_t nxt_s;
  logic [15:0] tcount;
  logic [15:0] cmp_a;
  logic hit_a;
  logic hit_b;
  logic roll;
  logic run;
  logic steady;
  logic wr;
  logic [2:0] idx;
  logic ev;
  logic rise;
  logic fall;

  if (AW < 5 || AW > 32) begin : g_chk
    $error("output_compare_channel: AW must lie in 5..32");
  end

  function automatic logic [2:0] decode(input logic [AW-1:0] a);
    logic [31:0] wide;
    logic [11:0] lo;
    wide = 32'(a);
    lo = wide[11:0];
    // any address bit above the register window marks an unmapped access
    if (wide[31:12] != 20'h00000) begin
      return `OCC_IDX_NONE;
    end else if (lo == `OCC_CTRL_OFS) begin
      return `OCC_IDX_CTRL;
    end else if (lo == `OCC_PRI_OFS) begin
      return `OCC_IDX_PRI;
    end else if (lo == `OCC_SEC_OFS) begin
      return `OCC_IDX_SEC;
    end else if (lo == `OCC_CFG_OFS) begin
      return `OCC_IDX_CFG;
    end else if (lo == `OCC_STS_OFS) begin
      return `OCC_IDX_STS;
    end else if (lo == `OCC_CLR_OFS) begin
      return `OCC_IDX_CLR;
    end else if (lo == `OCC_IEN_OFS) begin
      return `OCC_IDX_IEN;
    end else begin
      return `OCC_IDX_NONE;
    end
  endfunction : decode

  function automatic logic is_pwm(input mode_t m);
    return (m == mode_pwm) || (m == mode_pwm_fault);
  endfunction : is_pwm

  // ----------------------------------------
  // time base and compare
  // ----------------------------------------
  assign tcount = s_ff.tsel ? tmr_b_count : tmr_a_count;
  assign roll = s_ff.tsel ? tmr_b_rollover : tmr_a_rollover;
  // pwm compares against the latched duty, other modes against primary
  assign cmp_a = is_pwm(s_ff.mode) ? s_ff.duty : s_ff.pri;

  compare_match_unit #(.W(16)) u_match_a (
    .pclk(pclk),
    .presetn(presetn),
    .count(tcount),
    .cmp(cmp_a),
    .hit(hit_a)
  );

  compare_match_unit #(.W(16)) u_match_b (
    .pclk(pclk),
    .presetn(presetn),
    .count(tcount),
    .cmp(s_ff.sec),
    .hit(hit_b)
  );

  assign idx = decode(paddr);
  assign wr = psel && penable && pwrite;
  assign run = !(s_ff.idle_stop && cpu_idle);
  assign steady = (s_ff.mode == s_ff.last_mode);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_s = s_ff;
    rise = 1'b0;
    fall = 1'b0;
    ev = 1'b0;
    // mode entry sets the starting level one clock after the write
    if (!steady) begin
      nxt_s.last_mode = s_ff.mode;
      nxt_s.done = 1'b0;
      nxt_s.duty = s_ff.pri;
      case (s_ff.mode)
        mode_rise: nxt_s.out = 1'b0;
        mode_fall: nxt_s.out = 1'b1;
        mode_toggle: nxt_s.out = s_ff.out;
        mode_one_pulse: nxt_s.out = 1'b0;
        mode_pulse_train: nxt_s.out = 1'b0;
        mode_pwm: nxt_s.out = (s_ff.pri != 16'h0000);
        mode_pwm_fault: nxt_s.out = (s_ff.pri != 16'h0000);
        default: nxt_s.out = 1'b0;
      endcase
    end else if (run) begin
      case (s_ff.mode)
        mode_rise: begin
          if (hit_a) begin
            nxt_s.out = 1'b1;
          end
        end
        mode_fall: begin
          if (hit_a) begin
            nxt_s.out = 1'b0;
          end
        end
        mode_toggle: begin
          if (hit_a) begin
            nxt_s.out = !s_ff.out;
          end
        end
        mode_one_pulse, mode_pulse_train: begin
          if (!s_ff.done) begin
            if (hit_a) begin
              nxt_s.out = 1'b1;
            end
            if (hit_b) begin
              nxt_s.out = 1'b0;
              nxt_s.done = (s_ff.mode == mode_one_pulse);
            end
          end
        end
        mode_pwm, mode_pwm_fault: begin
          if (hit_a) begin
            nxt_s.out = 1'b0;
          end
          // rollover wins over a duty match in the same clock
          if (roll) begin
            nxt_s.duty = s_ff.sec;
            nxt_s.out = (s_ff.sec != 16'h0000);
          end
          if (s_ff.mode == mode_pwm_fault) begin
            if (!compare_fault_input_n) begin
              nxt_s.flt = 1'b1;
            end else if (roll) begin
              nxt_s.flt = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end
    rise = nxt_s.out && !s_ff.out;
    fall = !nxt_s.out && s_ff.out;
    if (steady && run) begin
      case (s_ff.mode)
        mode_rise: ev = rise;
        mode_fall, mode_one_pulse, mode_pulse_train: ev = fall;
        mode_toggle: ev = rise || fall;
        mode_pwm_fault: ev = s_ff.flt_n_prev && !compare_fault_input_n;
        default: ev = 1'b0;
      endcase
    end
    nxt_s.flt_n_prev = compare_fault_input_n;
    // a new event beats a clear in the same clock
    nxt_s.sts = (s_ff.sts && !(wr && idx == `OCC_IDX_CLR && pwdata[`OCC_EVT_BIT])) || ev;
    // register writes
    if (wr) begin
      case (idx)
        `OCC_IDX_CTRL: begin
          nxt_s.idle_stop = pwdata[`OCC_IDLE_BIT];
          nxt_s.mode = mode_t'(pwdata[`OCC_MODE_MSB:`OCC_MODE_LSB]);
        end
        `OCC_IDX_PRI: nxt_s.pri = pwdata[15:0];
        `OCC_IDX_SEC: nxt_s.sec = pwdata[15:0];
        `OCC_IDX_CFG: nxt_s.tsel = pwdata[`OCC_TSEL_BIT];
        `OCC_IDX_IEN: nxt_s.ien = pwdata[`OCC_EVT_BIT];
        default: ;
      endcase
    end
    if (nxt_s.mode != mode_pwm_fault) begin
      nxt_s.flt = 1'b0;
    end
    // read data captured in the setup phase
    if (psel && !penable) begin
      case (idx)
        `OCC_IDX_CTRL: begin
          nxt_s.rdata = '0;
          nxt_s.rdata[`OCC_IDLE_BIT] = s_ff.idle_stop;
          nxt_s.rdata[`OCC_FLT_BIT] = s_ff.flt;
          nxt_s.rdata[`OCC_MODE_MSB:`OCC_MODE_LSB] = s_ff.mode;
        end
        `OCC_IDX_PRI: nxt_s.rdata = {16'h0000, s_ff.pri};
        `OCC_IDX_SEC: nxt_s.rdata = {16'h0000, s_ff.sec};
        `OCC_IDX_CFG: nxt_s.rdata = {31'h0000_0000, s_ff.tsel};
        `OCC_IDX_STS: nxt_s.rdata = {31'h0000_0000, s_ff.sts};
        `OCC_IDX_IEN: nxt_s.rdata = {31'h0000_0000, s_ff.ien};
        default: nxt_s.rdata = `OCC_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = s_ff.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && (idx == `OCC_IDX_NONE);
  assign compare_output_pin_o = s_ff.out;
  // released while disabled or while a fault holds the pin
  assign compare_output_pin_oe_n = (s_ff.mode == mode_off) || s_ff.flt;
  assign gpio_owned = (s_ff.mode == mode_off);
  assign irq = s_ff.sts && s_ff.ien;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_reserved_zero: assert property (
    (psel && !penable && !pwrite && idx == `OCC_IDX_CTRL) |=>
      (prdata[15:14] == 2'b00 && prdata[12:5] == 8'h00 && prdata[3] == 1'b0))
    else $error("reserved control bits not zero");
  a_idle_halt: assert property (
    (s_ff.idle_stop && cpu_idle && steady) |=> $stable(compare_output_pin_o))
    else $error("output moved while halted in idle");
  a_rise_match: assert property (
    (s_ff.mode == mode_rise && steady && run && hit_a) |=> compare_output_pin_o)
    else $error("match did not drive output high");
  a_fall_match: assert property (
    (s_ff.mode == mode_fall && steady && run && hit_a) |=> !compare_output_pin_o)
    else $error("match did not drive output low");
  a_toggle_match: assert property (
    (s_ff.mode == mode_toggle && steady && run && hit_a) |=>
      (compare_output_pin_o != $past(compare_output_pin_o)))
    else $error("match did not toggle output");
  a_pulse_entry: assert property (
    (!steady && (s_ff.mode == mode_one_pulse || s_ff.mode == mode_pulse_train)) |=>
      !compare_output_pin_o)
    else $error("pulse mode did not start low");
  a_one_pulse_end: assert property (
    (s_ff.mode == mode_one_pulse && steady && s_ff.done && !wr) |=>
      (!compare_output_pin_o ##1 !compare_output_pin_o))
    else $error("second pulse after single pulse");
  a_pwm_entry: assert property (
    (!steady && is_pwm(s_ff.mode)) |=> (compare_output_pin_o == ($past(s_ff.pri) != 16'h0000)))
    else $error("pwm start level wrong");
  a_pwm_period: assert property (
    (is_pwm(s_ff.mode) && steady && run && roll && s_ff.sec != 16'h0000) |=>
      (compare_output_pin_o && s_ff.duty == $past(s_ff.sec)))
    else $error("pwm period start wrong");
  a_fault_set: assert property (
    (s_ff.mode == mode_pwm_fault && steady && run && !compare_fault_input_n && !wr) |=>
      (s_ff.flt && compare_output_pin_oe_n))
    else $error("fault not flagged");
  a_fault_hiz: assert property (
    (s_ff.flt && !(compare_fault_input_n && roll) && !wr) |=> compare_output_pin_oe_n)
    else $error("pin driven during fault");
  a_fault_gated: assert property (
    (s_ff.mode != mode_pwm_fault) |-> !s_ff.flt)
    else $error("fault flag set outside mode 111");
  a_pwm_nofault: assert property (
    (s_ff.mode == mode_pwm && !compare_fault_input_n) |-> !compare_output_pin_oe_n)
    else $error("fault input acted in mode 110");
  a_disable_pin: assert property (
    (wr && idx == `OCC_IDX_CTRL && pwdata[2:0] == 3'b000) |=> (compare_output_pin_oe_n && gpio_owned))
    else $error("disabled mode still drives pin");
  a_event_irq: assert property (
    (s_ff.mode == mode_rise && steady && run && hit_a && !s_ff.out && s_ff.ien && !wr) |=> irq)
    else $error("rising edge raised no interrupt");

  c_pulse_train: cover property (s_ff.mode == mode_pulse_train && fall);
  c_fault: cover property (s_ff.mode == mode_pwm_fault && $rose(s_ff.flt));
  c_irq: cover property ($rose(irq));
  c_pwm_cycle: cover property (s_ff.mode == mode_pwm && rise ##[1:300] fall);
endmodule : output_compare_channel

/* File: verif/occ_load_model.sv */
// load on the compare output pin, with a pull-down resistor
`timescale 1ns/1ps
module occ_load_model (
  input wire logic pin_o,
  input wire logic pin_oe_n,
  output logic pad
);
  // a released pin is pulled low by the load
  assign pad = pin_oe_n ? 1'b0 : pin_o;
endmodule : occ_load_model

/* File: verif/output_compare_channel_tb.sv */
// self-checking bench for the output compare channel
`timescale 1ns/1ps
`include "occ_map.svh"
`define CHK(nm, e, g) \
  n_compared++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("Error %s expected %h seen %h", nm, e, g); \
  end
module output_compare_channel_tb;
  import occ_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, tsel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] cnt_a, cnt_b, p, q;
  logic roll_a, roll_b, cpu_idle, fault_n, pin_o, pin_oe_n, gpio_owned, irq, pad;
  int failures, n_compared, cyc, seed;

  output_compare_channel dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tmr_a_count(cnt_a), .tmr_a_rollover(roll_a), .tmr_b_count(cnt_b),
    .tmr_b_rollover(roll_b), .cpu_idle(cpu_idle), .compare_fault_input_n(fault_n),
    .compare_output_pin_o(pin_o), .compare_output_pin_oe_n(pin_oe_n), .gpio_owned(gpio_owned), .irq(irq));
  occ_load_model load (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .pad(pad));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ----------------------------------------
  // bus and timer drivers
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask : rchk

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : wt

  // step the selected timer onto v, then let the pin settle
  task automatic cnt(input logic [15:0] v);
    @(posedge pclk);
    if (tsel) begin
      cnt_b <= v;
    end else begin
      cnt_a <= v;
    end
    wt(3);
  endtask : cnt

  task automatic roll();
    @(posedge pclk);
    roll_a <= 1'b1;
    @(posedge pclk);
    roll_a <= 1'b0;
    wt(1);
  endtask : roll

  function automatic logic entry_lvl(input int m);
    return (m == 2) ? 1'b1 : 1'b0;
  endfunction : entry_lvl

  task automatic start(input int m);
    p = 16'h0010 + 16'($random(seed) & 32'h7fff);
    q = p + 16'h0100;
    apb(1'b1, `OCC_CTRL_OFS, 32'h0);
    apb(1'b1, `OCC_PRI_OFS, {16'h0, p});
    apb(1'b1, `OCC_SEC_OFS, {16'h0, q});
    apb(1'b1, `OCC_CLR_OFS, 32'h1);
    apb(1'b1, `OCC_CTRL_OFS, 32'(m));
    wt(2);
  endtask : start

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_edge(input int m);
    tsel = (m == 3);
    apb(1'b1, `OCC_CFG_OFS, {31'h0, tsel});
    start(m);
    `CHK("entry level", entry_lvl(m), pin_o)
    `CHK("pin driven", 1'b0, pin_oe_n)
    `CHK("gpio released", 1'b0, gpio_owned)
    cnt(p);
    `CHK("match level", ~entry_lvl(m), pin_o)
    `CHK("edge irq", 1'b1, irq)
    rchk("status", `OCC_STS_OFS, 32'h1);
    cnt(16'h0);
    $display("test edge mode %0d done", m);
  endtask : t_edge

  task automatic t_pulse(input int m);
    tsel = 1'b0;
    apb(1'b1, `OCC_CFG_OFS, 32'h0);
    start(m);
    `CHK("pulse entry", 1'b0, pin_o)
    cnt(p);
    `CHK("pulse high", 1'b1, pin_o)
    cnt(q);
    `CHK("pulse low", 1'b0, pin_o)
    `CHK("fall irq", 1'b1, irq)
    cnt(p);
    `CHK("pulse again", (m == 5), pin_o)
    cnt(16'h0);
    $display("test pulse mode %0d done", m);
  endtask : t_pulse

  task automatic t_pwm(input int m);
    start(m);
    `CHK("pwm entry", 1'b1, pin_o)
    cnt(p);
    `CHK("duty end", 1'b0, pin_o)
    roll();
    `CHK("period start", 1'b1, pin_o)
    @(posedge pclk) fault_n <= 1'b0;
    wt(3);
    `CHK("fault release", (m == 7), pin_oe_n)
    `CHK("load level", (m != 7), pad)
    `CHK("fault irq", (m == 7), irq)
    rchk("fault flag", `OCC_CTRL_OFS, 32'(m) | ((m == 7) ? 32'h10 : 32'h0));
    fault_n <= 1'b1;
    roll();
    rchk("flag cleared", `OCC_CTRL_OFS, 32'(m));
    cnt(16'h0);
    $display("test pwm mode %0d done", m);
  endtask : t_pwm

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    seed = 79;
    {presetn, psel, penable, pwrite, roll_a, roll_b, cpu_idle, tsel} = 8'h0;
    {paddr, pwdata, cnt_a, cnt_b} = 0;
    fault_n = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    wt(1);
    `CHK("reset oe_n", 1'b1, pin_oe_n)
    `CHK("reset gpio", 1'b1, gpio_owned)
    rchk("ctrl reset", `OCC_CTRL_OFS, 32'h0);
    apb(1'b1, `OCC_CTRL_OFS, 32'h0000_fff8);
    rchk("ctrl reserved", `OCC_CTRL_OFS, 32'h0000_2000);
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    $display("test registers done");
    apb(1'b1, `OCC_IEN_OFS, 32'h1);
    cpu_idle <= 1'b1;
    for (int m = 1; m < 4; m++) begin
      t_edge(m);
    end
    tsel = 1'b0;
    apb(1'b1, `OCC_CFG_OFS, 32'h0);
    start(32'h2001);
    cnt(p);
    `CHK("idle halt", 1'b0, pin_o)
    cnt(16'h0);
    @(posedge pclk) cpu_idle <= 1'b0;
    $display("test idle done");
    t_pulse(4);
    t_pulse(5);
    t_pwm(6);
    t_pwm(7);
    apb(1'b1, `OCC_IEN_OFS, 32'h0);
    wt(1);
    `CHK("masked irq", 1'b0, irq)
    conclude();
  end
endmodule : output_compare_channel_tb
